// ==== core/eeprom_regs.vh ====
/*
 Constants for the two-wire serial EEPROM slave: select byte layout,
 erased contents, packet layout and write cycle timing.
 Assumes it is included once per file by its bare name.
*/
`ifndef EEPROM_REGS_VH
`define EEPROM_REGS_VH
// Select byte fields
`define SEL_DIR_BIT 0
`define SEL_STRAP_LSB 1
`define SEL_STRAP_MSB 3
`define SEL_TYPE_LSB 4
`define SEL_TYPE_MSB 7
// Erased memory contents
`define ERASED_WORD 32'hFFFF_FFFF
// Packet of four bytes with six check bits
`define ECC_BITS 6
`define ECC_SPAN 39
// Timing
`define CLK_PERIOD_NS 50
`define INTERNAL_WRITE_TIME_NS 5000000
`endif

// ==== core/i2c_eeprom_slave.v ====
/*
 Slave-side protocol logic of a two-wire serial EEPROM with packet ECC.
 Assumes: one system clock; bus pins, straps and protect input are
 asynchronous and are synchronised here; the pad resolves sda_oe.
*/
`timescale 1ns/1ps
`include "eeprom_regs.vh"
module i2c_eeprom_slave #(
   parameter ADDR_W       = 15,
   parameter PAGE_W       = 7,
   parameter DEV_TYPE     = 4'b0110, // Arbitrary type identifier value
   parameter WRITE_CYCLES = `INTERNAL_WRITE_TIME_NS / `CLK_PERIOD_NS
) (
   // Clock and reset
   input  wire clock,
   input  wire rst,
   // Two-wire bus
   input  wire scl_in,
   input  wire sda_in,
   output wire sda_out,
   output wire sda_oe,
   // Straps and protect
   input  wire write_protect_in,
   input  wire strap_addr_bit0,
   input  wire strap_addr_bit1,
   input  wire strap_addr_bit2,
   // Status
   output wire write_busy
);
   localparam NPKT = 1 << (ADDR_W - 2);
   localparam PG   = 1 << PAGE_W;
   localparam ST_IDLE = 3'd0;
   localparam ST_DEV  = 3'd1;
   localparam ST_AH   = 3'd2;
   localparam ST_AL   = 3'd3;
   localparam ST_WR   = 3'd4;
   localparam ST_RD   = 3'd5;
   localparam ST_BUSY = 3'd6;
   // Hamming position of data bit i, skipping power-of-two slots
   function [5:0] hpos;
      input integer i;
      integer p, n;
      begin
         hpos = 6'd0;
         n = 0;
         for (p = 1; p < `ECC_SPAN; p = p + 1) begin
            if ((p & (p - 1)) != 0) begin
               if (n == i) hpos = p[5:0];
               n = n + 1;
            end
         end
      end
   endfunction
   // Check bits: xor of the positions of all set data bits
   function [`ECC_BITS-1:0] ecc_gen;
      input [31:0] d;
      integer i;
      begin
         ecc_gen = 6'd0;
         for (i = 0; i < 32; i = i + 1)
            ecc_gen = ecc_gen ^ (hpos(i) & {6{d[i]}});
      end
   endfunction
   // Single-bit correction from the syndrome
   function [31:0] ecc_fix;
      input [31:0]          d;
      input [`ECC_BITS-1:0] c;
      integer i;
      reg [5:0] s;
      begin
         s = ecc_gen(d) ^ c;
         ecc_fix = d;
         for (i = 0; i < 32; i = i + 1)
            if (s == hpos(i)) ecc_fix[i] = ~d[i];
      end
   endfunction
   reg  [5:0]        meta_ff;
   reg  [5:0]        sync_ff;
   reg               scl_p_ff;
   reg               sda_p_ff;
   reg  [2:0]        phase_ff;
   reg  [3:0]        bit_ff;
   reg  [7:0]        shift_ff;
   reg               ack_ff;
   reg               rw_ff;
   reg               acked_ff;
   reg               wp_seen_ff;
   reg               sda_oe_ff;
   reg  [7:0]        addr_hi_ff;
   reg  [ADDR_W-1:0] addr_ff;
   reg  [7:0]        rbyte_ff;
   reg  [31:0]       wcnt_ff;
   reg  [PAGE_W-1:0] cidx_ff;
   reg               cdone_ff;
   reg  [ADDR_W-PAGE_W-1:0] row_ff;
   reg  [31:0]       mem_d [0:NPKT-1];
   reg  [5:0]        mem_c [0:NPKT-1];
   reg  [7:0]        pg_d [0:PG-1];
   reg  [PG-1:0]     pg_m;
   reg  [PAGE_W+7:0] fq [0:1];
   reg  [1:0]        fwp_ff;
   reg  [1:0]        frp_ff;
   reg               nxt_oe;
   reg  [31:0]       cword;
   integer           k;
   // Synchronised pins: scl, sda, protect, straps
   wire       scl_s = sync_ff[0];
   wire       sda_s = sync_ff[1];
   wire       wp_s  = sync_ff[2];
   wire [2:0] strap = sync_ff[5:3];
   wire scl_rise  = scl_s & ~scl_p_ff;
   wire scl_fall  = ~scl_s & scl_p_ff;
   wire start_det = scl_s & scl_p_ff & sda_p_ff & ~sda_s;
   wire stop_det  = scl_s & scl_p_ff & ~sda_p_ff & sda_s;
   wire [7:0] rx_byte = {shift_ff[6:0], sda_s};
   wire [15:0] a16 = {addr_hi_ff, rx_byte};
   wire sel_match = (rx_byte[`SEL_TYPE_MSB:`SEL_TYPE_LSB] == DEV_TYPE) &&
                    (rx_byte[`SEL_STRAP_MSB:`SEL_STRAP_LSB] == strap);
   // Two-entry buffer between byte receiver and page latch
   wire [1:0] fcount   = fwp_ff - frp_ff;
   wire       f_in_rdy = (fcount != 2'd2);
   wire       f_out_v  = (fcount != 2'd0);
   wire       commit_run = (phase_ff == ST_BUSY) & ~f_out_v & ~cdone_ff;
   wire       f_out_rdy  = ~commit_run;
   wire       wr_ok = ~wp_seen_ff & f_in_rdy;
   wire       f_push = scl_rise & (phase_ff == ST_WR) & (bit_ff == 4'd7) & wr_ok;
   wire       f_pop  = f_out_v & f_out_rdy;
   wire [PAGE_W+7:0] f_head = fq[frp_ff[0]];
   // Read path with correction
   wire [ADDR_W-3:0] rpk   = addr_ff[ADDR_W-1:2];
   wire [31:0]       rword = ecc_fix(mem_d[rpk], mem_c[rpk]);
   wire [7:0]        rd_byte = rword[{addr_ff[1:0], 3'b000} +: 8];
   // Commit path: whole packet rewritten with new lane
   wire [ADDR_W-1:0] caddr = {row_ff, cidx_ff};
   wire [ADDR_W-3:0] cpk   = caddr[ADDR_W-1:2];
   always @* begin
      cword = ecc_fix(mem_d[cpk], mem_c[cpk]);
      cword[{caddr[1:0], 3'b000} +: 8] = pg_d[cidx_ff];
   end
   // Pin synchronisers
   always @(posedge clock) begin
      if (rst) begin
         meta_ff <= 6'b00_0011;
         sync_ff <= 6'b00_0011;
      end else begin
         meta_ff <= {strap_addr_bit2, strap_addr_bit1, strap_addr_bit0,
                     write_protect_in, sda_in, scl_in};
         sync_ff <= meta_ff;
      end
   end
   // Protect seen from Start to end of address bytes, set wins
   always @(posedge clock) begin
      if (rst)
         wp_seen_ff <= 1'b0;
      else if (start_det && phase_ff != ST_BUSY)
         wp_seen_ff <= wp_s;
      else if (wp_s && (phase_ff == ST_DEV || phase_ff == ST_AH || phase_ff == ST_AL))
         wp_seen_ff <= 1'b1;
   end
   // SDA drive decided at each falling SCL
   always @* begin
      case (phase_ff)
         ST_DEV, ST_AH, ST_AL, ST_WR: nxt_oe = (bit_ff == 4'd8) & ack_ff;
         ST_RD: nxt_oe = (bit_ff < 4'd8) ? ~rbyte_ff[3'd7 - bit_ff[2:0]] : 1'b0;
         default: nxt_oe = 1'b0;
      endcase
   end
   // Protocol engine
   always @(posedge clock) begin
      if (rst) begin
         scl_p_ff   <= 1'b1;
         sda_p_ff   <= 1'b1;
         phase_ff   <= ST_IDLE;
         bit_ff     <= 4'd0;
         shift_ff   <= 8'h00;
         ack_ff     <= 1'b0;
         rw_ff      <= 1'b0;
         acked_ff   <= 1'b0;
         sda_oe_ff  <= 1'b0;
         addr_hi_ff <= 8'h00;
         addr_ff    <= {ADDR_W{1'b0}};
         rbyte_ff   <= 8'h00;
         wcnt_ff    <= 32'h0000_0000;
         cidx_ff    <= {PAGE_W{1'b0}};
         cdone_ff   <= 1'b0;
         row_ff     <= {(ADDR_W-PAGE_W){1'b0}};
      end else begin
         scl_p_ff <= scl_s;
         sda_p_ff <= sda_s;
         if (phase_ff == ST_BUSY) begin
            sda_oe_ff <= 1'b0;
            if (wcnt_ff != 32'h0000_0000)
               wcnt_ff <= wcnt_ff - 1'b1;
            if (commit_run) begin
               cidx_ff <= cidx_ff + 1'b1;
               if (cidx_ff == {PAGE_W{1'b1}})
                  cdone_ff <= 1'b1;
            end
            if (wcnt_ff == 32'h0000_0000 && cdone_ff)
               phase_ff <= ST_IDLE;
         end else if (start_det) begin
            phase_ff  <= ST_DEV;
            bit_ff    <= 4'd0;
            ack_ff    <= 1'b0;
            acked_ff  <= 1'b0;
            sda_oe_ff <= 1'b0;
         end else if (stop_det) begin
            sda_oe_ff <= 1'b0;
            if (phase_ff == ST_WR && bit_ff == 4'd1 && acked_ff) begin
               phase_ff <= ST_BUSY;
               wcnt_ff  <= WRITE_CYCLES;
               cidx_ff  <= {PAGE_W{1'b0}};
               cdone_ff <= 1'b0;
            end else
               phase_ff <= ST_IDLE;
         end else if (scl_rise && phase_ff != ST_IDLE) begin
            shift_ff <= rx_byte;
            bit_ff   <= (bit_ff == 4'd8) ? 4'd0 : bit_ff + 1'b1;
            if (bit_ff == 4'd7) begin
               case (phase_ff)
                  ST_DEV: begin
                     ack_ff <= sel_match;
                     rw_ff  <= rx_byte[`SEL_DIR_BIT];
                     if (!sel_match)
                        phase_ff <= ST_IDLE;
                  end
                  ST_AH: begin
                     addr_hi_ff <= rx_byte;
                     ack_ff     <= 1'b1;
                  end
                  ST_AL: begin
                     addr_ff <= a16[ADDR_W-1:0];
                     row_ff  <= a16[ADDR_W-1:PAGE_W];
                     ack_ff  <= 1'b1;
                  end
                  ST_WR: begin
                     ack_ff   <= wr_ok;
                     acked_ff <= wr_ok;
                     if (wr_ok)
                        addr_ff <= {addr_ff[ADDR_W-1:PAGE_W],
                                    addr_ff[PAGE_W-1:0] + 1'b1};
                  end
                  ST_RD: addr_ff <= addr_ff + 1'b1;
                  default: ack_ff <= 1'b0;
               endcase
            end else if (bit_ff == 4'd8) begin
               case (phase_ff)
                  ST_DEV: begin
                     phase_ff <= rw_ff ? ST_RD : ST_AH;
                     rbyte_ff <= rd_byte;
                  end
                  ST_AH: phase_ff <= ST_AL;
                  ST_AL: phase_ff <= ST_WR;
                  ST_RD: begin
                     if (!sda_s)
                        rbyte_ff <= rd_byte;
                     else
                        phase_ff <= ST_IDLE;
                  end
                  default: phase_ff <= phase_ff;
               endcase
            end
         end else if (scl_fall) begin
            sda_oe_ff <= nxt_oe;
         end
      end
   end
   // Two-entry buffer storage and pointers
   always @(posedge clock) begin
      if (rst) begin
         fwp_ff <= 2'd0;
         frp_ff <= 2'd0;
      end else begin
         if (f_push) begin
            fq[fwp_ff[0]] <= {addr_ff[PAGE_W-1:0], rx_byte};
            fwp_ff        <= fwp_ff + 1'b1;
         end
         if (f_pop)
            frp_ff <= frp_ff + 1'b1;
      end
   end
   // Page latch: cleared when a new address is taken, filled from buffer
   always @(posedge clock) begin
      if (rst)
         pg_m <= {PG{1'b0}};
      else if (scl_rise && phase_ff == ST_AL && bit_ff == 4'd7)
         pg_m <= {PG{1'b0}};
      else if (f_pop) begin
         pg_d[f_head[PAGE_W+7:8]] <= f_head[7:0];
         pg_m[f_head[PAGE_W+7:8]] <= 1'b1;
      end
   end
   // Packet array: erased at reset, rewritten per latched byte
   always @(posedge clock) begin
      if (rst) begin
         for (k = 0; k < NPKT; k = k + 1) begin
            mem_d[k] <= `ERASED_WORD;
            mem_c[k] <= ecc_gen(`ERASED_WORD);
         end
      end else if (commit_run && pg_m[cidx_ff]) begin
         mem_d[cpk] <= cword;
         mem_c[cpk] <= ecc_gen(cword);
      end
   end
   // Open-drain output and status
   assign sda_out    = 1'b0;
   assign sda_oe     = sda_oe_ff;
   assign write_busy = (phase_ff == ST_BUSY);
endmodule // i2c_eeprom_slave

// ==== tb/i2c_eeprom_slave_properties.sv ====
/*
 Checker bound to the EEPROM slave top module.
 Assumes one clock domain and bus phases of at least 4 clocks.
*/
`timescale 1ns/1ps
module eeprom_slave_checker #(
   parameter WRITE_CYCLES = 200
) (
   // Clock and reset
   input wire logic clock,
   input wire logic rst,
   // Bus, protect and status
   input wire logic scl_in,
   input wire logic sda_in,
   input wire logic sda_out,
   input wire logic sda_oe,
   input wire logic write_protect_in,
   input wire logic write_busy
);
   logic [31:0] busy_len_ff;
   logic [4:0]  idle_len_ff;
   // Length of the write cycle and of SCL held high
   always @(posedge clock) begin
      if (rst) begin
         busy_len_ff <= 32'h0000_0000;
         idle_len_ff <= 5'h00;
      end else begin
         busy_len_ff <= write_busy ? busy_len_ff + 32'h0000_0001 : 32'h0000_0000;
         idle_len_ff <= !scl_in ? 5'h00 : idle_len_ff + {4'h0, idle_len_ff != 5'h1F};
      end
   end
   default clocking cb @(posedge clock); endclocking
   default disable iff (rst);
   AST_OPEN_DRAIN: assert property (sda_out == 1'b0)
      else $error("sda_out driven high");
   AST_OE_IN_SCL_LOW: assert property ($changed(sda_oe) |-> !$past(scl_in))
      else $error("sda_oe moved with SCL high");
   AST_BUSY_RELEASED: assert property (write_busy |-> !sda_oe)
      else $error("SDA driven in write cycle");
   AST_IDLE_RELEASED: assert property (idle_len_ff >= 5'h0C |-> !sda_oe)
      else $error("SDA driven on idle bus");
   AST_BUSY_AT_STOP: assert property ($rose(write_busy) |-> scl_in && sda_in)
      else $error("write cycle began outside stop");
   AST_BUSY_UNPROTECTED: assert property ($rose(write_busy) |-> !write_protect_in)
      else $error("write cycle under protect");
   AST_BUSY_LENGTH: assert property ($fell(write_busy) |-> busy_len_ff >= WRITE_CYCLES - 1)
      else $error("write cycle too short");
   AST_BUSY_ENDS: assert property ($rose(write_busy) |-> ##[1:1000] !write_busy)
      else $error("write cycle never ended");
   COV_WRITE: cover property ($rose(write_busy));
   COV_POLL: cover property (write_busy && !scl_in);
   COV_PROT_ACK: cover property ($rose(sda_oe) && write_protect_in);
endmodule // eeprom_slave_checker

bind i2c_eeprom_slave eeprom_slave_checker #(.WRITE_CYCLES(WRITE_CYCLES)) u_eeprom_slave_checker (
   .clock(clock), .rst(rst), .scl_in(scl_in), .sda_in(sda_in), .sda_out(sda_out),
   .sda_oe(sda_oe), .write_protect_in(write_protect_in), .write_busy(write_busy)
);

// ==== tb/i2c_master_model.sv ====
/*
 Bus master model driving SCL and SDA from the falling clock edge.
 Assumes the bench resolves SDA with a pull-up and calls the tasks.
*/
`timescale 1ns/1ps
module i2c_master_model (
   // Clock
   input  wire logic       clock,
   // Resolved data line
   input  wire logic       sda_bus,
   // Driven pins, SCL idles high outside frames
   output logic            scl,
   output logic            sda_drv,
   // Bits seen on the line for each byte
   output logic            obs_valid,
   output logic [8:0]      obs_val
);
   // Idle bus at time zero
   initial begin
      scl = 1'b1;
      sda_drv = 1'b1;
      obs_valid = 1'b0;
      obs_val = 9'h000;
   end
   task automatic pause(input int n);
      repeat (n) @(negedge clock);
   endtask
   // Start or repeated start: SDA falls with SCL high
   task automatic start();
      sda_drv = 1'b1;
      pause(4);
      scl = 1'b1;
      pause(4);
      sda_drv = 1'b0;
      pause(4);
      scl = 1'b0;
   endtask
   // Eight bits MSB first and the ninth bit, SDA moved only with SCL low
   task automatic byte_io(input logic [7:0] tx, input logic ninth);
      logic [8:0] bits;
      logic [8:0] rx;
      bits = {tx, ninth};
      for (int i = 8; i >= 0; i--) begin
         pause(2);
         sda_drv = bits[i];
         pause(2);
         scl = 1'b1;
         pause(2);
         rx[i] = sda_bus;
         pause(2);
         scl = 1'b0;
      end
      obs_val = rx;
      obs_valid = 1'b1;
      pause(1);
      obs_valid = 1'b0;
   endtask
   // Stop: SDA rises with SCL high, bus left idle
   task automatic stop();
      sda_drv = 1'b0;
      pause(4);
      scl = 1'b1;
      pause(4);
      sda_drv = 1'b1;
      pause(4);
   endtask
endmodule // i2c_master_model

// ==== tb/i2c_serial_eeprom_slave_tb.sv ====
/*
 Self-checking bench for the EEPROM slave with a bus master model.
 Assumes the checker is bound to the design by its own file.
*/
`timescale 1ns/1ps
module i2c_serial_eeprom_slave_tb;
   localparam logic [3:0] DEV_ID = 4'h6; // Arbitrary type code
   localparam logic [2:0] STRAP = 3'b101;
   logic       clock, rst, wp, busy, oe, sda_o, scl, sda_drv, obs_valid;
   logic [8:0] obs_val;
   logic [2:0] strap;
   logic [7:0] seed;
   logic [7:0] mem [0:32767];
   logic [8:0] exp_q[$];
   int         error_cnt, num_checks, cyc = 0;
   wire        sda_bus = oe ? (sda_drv & sda_o) : sda_drv; // Pull-up on the released line

   i2c_eeprom_slave #(.DEV_TYPE(DEV_ID), .WRITE_CYCLES(200)) u_i2c_eeprom_slave (
      .clock(clock), .rst(rst), .scl_in(scl), .sda_in(sda_bus), .sda_out(sda_o),
      .sda_oe(oe), .write_protect_in(wp), .strap_addr_bit0(strap[0]),
      .strap_addr_bit1(strap[1]), .strap_addr_bit2(strap[2]), .write_busy(busy)
   );
   i2c_master_model u_i2c_master_model (
      .clock(clock), .sda_bus(sda_bus), .scl(scl), .sda_drv(sda_drv),
      .obs_valid(obs_valid), .obs_val(obs_val)
   );
   initial begin
      clock = 1'b0;
      forever #25 clock = ~clock;
   end
   function automatic logic [7:0] lfsr(input logic [7:0] s);
      return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
   endfunction
   function automatic logic [7:0] peek(input logic [14:0] a);
      return mem[a];
   endfunction
   task automatic check(input logic [8:0] seen, input logic [8:0] expv, input string what);
      num_checks++;
      if (seen !== expv) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", what, expv, seen);
      end
   endtask
   task automatic summarize();
      $display("checks %0d errors %0d", num_checks, error_cnt);
      if (error_cnt == 0 && num_checks > 0) $display("TEST PASSED");
      else $display("TEST FAILED");
      $finish;
   endtask
   // Note the expectation, then move one byte
   task automatic xfer(input logic [7:0] tx, input logic ninth, input logic [8:0] expv);
      exp_q.push_back(expv);
      u_i2c_master_model.byte_io(tx, ninth);
   endtask
   task automatic sel(input logic [2:0] st, input logic rw, input logic ack);
      u_i2c_master_model.start();
      xfer({DEV_ID, st, rw}, 1'b1, {DEV_ID, st, rw, ~ack});
   endtask
   task automatic addr(input logic [15:0] a);
      xfer(a[15:8], 1'b1, {a[15:8], 1'b0});
      xfer(a[7:0], 1'b1, {a[7:0], 1'b0});
   endtask
   task automatic stop_wait();
      u_i2c_master_model.stop();
      repeat (8) @(negedge clock);
   endtask
   // Stop, poll while busy, then wait for the cycle to end
   task automatic commit();
      stop_wait();
      check({8'h00, busy}, 9'h001, "write_busy");
      sel(STRAP, 1'b0, 1'b0);
      u_i2c_master_model.stop();
      for (int i = 0; i < 1000 && busy !== 1'b0; i++) @(negedge clock);
      sel(STRAP, 1'b0, 1'b1);
      u_i2c_master_model.stop();
   endtask
   task automatic pwrite(input logic [15:0] a, input int n);
      logic [14:0] p;
      sel(STRAP, 1'b0, 1'b1);
      addr(a);
      for (int i = 0; i < n; i++) begin
         seed = lfsr(seed);
         p = {a[14:7], a[6:0] + i[6:0]};
         mem[p] = seed;
         xfer(seed, 1'b1, {seed, 1'b0});
      end
      commit();
   endtask
   // Read select then n bytes from a, the last one refused
   task automatic seqrd(input logic [14:0] a, input int n);
      sel(STRAP, 1'b1, 1'b1);
      for (int i = 0; i < n; i++) xfer(8'hFF, i == n - 1, {peek(a + i[14:0]), i == n - 1});
      u_i2c_master_model.stop();
   endtask
   task automatic done(input int n);
      $display("test %0d done", n);
   endtask
   // Each observed byte against the oldest note
   always @(posedge obs_valid) check(obs_val, exp_q.pop_front(), "bus byte");
   // Cycle ceiling against a hung bus
   always @(posedge clock) begin
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         error_cnt++;
         summarize();
      end
   end
   // Main sequence
   initial begin
      rst = 1'b1;
      wp = 1'b0;
      strap = STRAP;
      seed = 8'h1D;
      for (int i = 0; i < 32768; i++) mem[i] = 8'hFF;
      repeat (2) @(negedge clock);
      rst = 1'b0;
      repeat (4) @(negedge clock);
      seqrd(15'h0000, 1);
      done(1);
      sel(STRAP ^ 3'b011, 1'b0, 1'b0);
      u_i2c_master_model.stop();
      u_i2c_master_model.start();
      xfer({~DEV_ID, STRAP, 1'b0}, 1'b1, {~DEV_ID, STRAP, 1'b0, 1'b1});
      u_i2c_master_model.stop();
      done(2);
      pwrite(16'h0002, 1);
      pwrite(16'h807E, 4);
      seqrd(15'h0002, 2);
      done(3);
      wp = 1'b1;
      sel(STRAP, 1'b0, 1'b1);
      addr(16'h0000);
      xfer(8'h5A, 1'b1, {8'h5A, 1'b1});
      stop_wait();
      check({8'h00, busy}, 9'h000, "write_busy");
      seqrd(15'h0000, 1);
      wp = 1'b0;
      done(4);
      sel(STRAP, 1'b0, 1'b1);
      addr(16'hFFFE);
      seqrd(15'h7FFE, 4);
      done(5);
      sel(STRAP, 1'b0, 1'b1);
      addr(16'h0100);
      stop_wait();
      check({8'h00, busy}, 9'h000, "write_busy");
      done(6);
      summarize();
   end
endmodule // i2c_serial_eeprom_slave_tb
